// ---- rtl/section_trail_sink.sv ----
`timescale 1ns/1ps
// Contract
// (R1) Even BIP-384 over previous frame minus regenerator overhead, compared to B2.
// (R2) Each mismatching parity block counts once; total feeds near count and backward value.
// (R3) M1 read every frame as unsigned far-end error count 0 to 255.
// (R4) K2 bits 6-8 equal 110 means remote defect, otherwise normal.
// (R5) Section AIS declared after x consecutive frames with K2 code 111.
// (R6) Section AIS cleared after x consecutive frames with any other code.
// (R7) Degrade defect from threshold and period; remote defect detected; degrade drives output.
// (R8) AIS drives trail fail and backward request; all ones output within 250 us.
// (R9) AIS report needs monitor, AIS defect, no server fail, and report enable.
// (R10) Remote report gated by monitor and enable; degrade report gated by monitor.
// (R11) Server fail report needs monitor, AIS defect and its report enable.
// (R12) Sum near and far errors; defect seconds from fail, equipment, remote defect.
// (R13) Monitor enable follows termination point mode; non-monitored suppresses reports.
// (R14) One-second tick publishes counts and defect seconds, then restarts accumulation.
module section_trail_sink
  import trail_sink_pkg::*;
#(
  parameter int unsigned ROW_LEN = ROW_BYTES,
  parameter int unsigned LANES   = BIP_LANES
) (
  input  wire logic              mclk_in,
  input  wire logic              rst_n_in,
  input  wire logic              link_clk_in,
  input  wire logic [7:0]        line_data_in,
  input  wire logic              frame_start_in,
  input  wire logic              incoming_server_fail_in,
  input  wire logic              equipment_defect_in,
  input  wire logic [15:0]       degrade_threshold_in,
  input  wire logic [3:0]        degrade_period_count_in,
  input  wire logic              one_second_tick_in,
  input  wire logic              termination_point_mode_in,
  input  wire logic              server_fail_report_enable_in,
  input  wire logic              alarm_indication_report_enable_in,
  input  wire logic              remote_defect_report_enable_in,
  output logic [7:0]             line_data_out,
  output logic                   frame_start_out,
  output logic                   trail_signal_fail_out,
  output logic                   trail_signal_degrade_out,
  output logic                   alarm_indication_report_out,
  output logic                   degrade_report_out,
  output logic                   remote_defect_report_out,
  output logic                   server_fail_report_out,
  output logic [CNT_W-1:0]       near_error_block_count_out,
  output logic [CNT_W-1:0]       far_error_block_count_out,
  output logic                   near_defect_second_out,
  output logic                   far_defect_second_out,
  output logic [8:0]             backward_error_value_out,
  output logic                   backward_defect_request_out
);
  // ------------------------------------------------------------------
  // Reset release in both domains
  // ------------------------------------------------------------------
  logic [1:0] mrst_sync_reg;
  logic [1:0] lrst_sync_reg;
  wire        mrst_n = mrst_sync_reg[1];
  wire        lrst_n = lrst_sync_reg[1];

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) mrst_sync_reg <= 2'h0;
    else           mrst_sync_reg <= {mrst_sync_reg[0], 1'b1};
  end

  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) lrst_sync_reg <= 2'h0;
    else           lrst_sync_reg <= {lrst_sync_reg[0], 1'b1};
  end

  // ------------------------------------------------------------------
  // Frame position, link domain
  // ------------------------------------------------------------------
  logic [12:0] col_reg;
  logic [3:0]  row_reg;
  logic        framed_reg;
  wire         last_col   = (col_reg == 13'(ROW_LEN - 1));
  // A frame start marks column 0, so the count moves on to column 1 and always names the byte now on the line.
  wire  [12:0] col_next   = frame_start_in ? 13'h0001 : (last_col ? 13'h0000 : col_reg + 13'h0001);
  wire  [3:0]  row_next   = frame_start_in ? 4'h0 : (last_col ? row_reg + 4'h1 : row_reg);
  wire         in_regenerator_overhead    = (row_reg < 4'(B2_ROW - 1)) && (col_reg < 13'(OH_COLS));
  wire         is_b2      = (row_reg == 4'(B2_ROW)) && (col_reg >= 13'(OH_COLS - REGENERATOR_OVERHEAD_COLS))
                            && (col_reg < 13'(OH_COLS - REGENERATOR_OVERHEAD_COLS + LANES)) && framed_reg;
  wire         is_k2      = (row_reg == 4'(K2_ROW)) && (col_reg == 13'(K2_COL)) && framed_reg;
  wire         is_m1      = (row_reg == 4'(M1_ROW)) && (col_reg == 13'(M1_COL)) && framed_reg;
  wire  [5:0]  lane_idx   = 6'(col_reg % 13'(LANES));

  always_ff @(posedge link_clk_in or negedge lrst_n) begin
    if (!lrst_n) begin
      col_reg    <= 13'h0000;
      row_reg    <= 4'h0;
      framed_reg <= 1'b0;
    end else begin
      col_reg    <= col_next;
      row_reg    <= row_next;
      framed_reg <= framed_reg | frame_start_in;
    end
  end

  // ------------------------------------------------------------------
  // Parity accumulation and check, link domain
  // ------------------------------------------------------------------
  logic [LANES*8-1:0] bip_acc_reg;
  logic [LANES*8-1:0] bip_prev_reg;
  logic [LANES*8-1:0] b2_rcvd_reg;
  logic [8:0]         blk_err_reg;
  logic [7:0]         far_err_reg;
  logic [2:0]         k2_code_reg;
  logic [2:0]         ais_run_reg;
  logic               ais_defect_reg;
  logic               frame_evt_tgl_reg;
  logic               prev_valid_reg;
  wire  [8:0]         blk_err_calc;
  wire                ais_frame = (k2_code_reg == K2_AIS_CODE);

  bip_lane_sum #(.LANES(LANES)) u_lane_sum (
    .calc_in    (bip_prev_reg),
    .rcvd_in    (b2_rcvd_reg),
    .errors_out (blk_err_calc)
  );

  always_ff @(posedge link_clk_in or negedge lrst_n) begin
    if (!lrst_n) begin
      bip_acc_reg    <= '0;
      bip_prev_reg   <= '0;
      b2_rcvd_reg    <= '0;
      prev_valid_reg <= 1'b0;
    end else begin
      if (frame_start_in) begin
        bip_prev_reg   <= bip_acc_reg; // R1
        bip_acc_reg    <= '0;
        prev_valid_reg <= framed_reg;
      end else if (framed_reg && !in_regenerator_overhead) begin
        bip_acc_reg[lane_idx*8 +: 8] <= bip_acc_reg[lane_idx*8 +: 8] ^ line_data_in; // R1
      end
      if (is_b2) b2_rcvd_reg[lane_idx*8 +: 8] <= line_data_in; // R1
    end
  end

  always_ff @(posedge link_clk_in or negedge lrst_n) begin
    if (!lrst_n) begin
      blk_err_reg       <= 9'h000;
      far_err_reg       <= 8'h00;
      k2_code_reg       <= 3'h0;
      ais_run_reg       <= 3'h0;
      ais_defect_reg    <= 1'b0;
      frame_evt_tgl_reg <= 1'b0;
    end else begin
      if (is_k2) k2_code_reg <= line_data_in[2:0]; // R4
      if (is_m1) far_err_reg <= line_data_in; // R3
      if (frame_start_in && framed_reg) begin
        blk_err_reg       <= prev_valid_reg ? blk_err_calc : 9'h000; // R2
        frame_evt_tgl_reg <= ~frame_evt_tgl_reg;
        if (ais_frame != ais_defect_reg) begin
          if (ais_run_reg == 3'(AIS_PERSIST - 1)) begin
            ais_defect_reg <= ais_frame; // R5 R6
            ais_run_reg    <= 3'h0;
          end else begin
            ais_run_reg <= ais_run_reg + 3'h1;
          end
        end else begin
          ais_run_reg <= 3'h0;
        end
      end
    end
  end

  // All ones replaces data at once, well inside the allowed action time.
  always_ff @(posedge link_clk_in or negedge lrst_n) begin
    if (!lrst_n) begin
      line_data_out   <= 8'h00;
      frame_start_out <= 1'b0;
    end else begin
      line_data_out   <= ais_defect_reg ? ALL_ONES_BYTE : line_data_in; // R8
      frame_start_out <= frame_start_in;
    end
  end

  // ------------------------------------------------------------------
  // Crossing to the management clock: frame toggle plus held words
  // ------------------------------------------------------------------
  // The per-frame words are stable for at least four rows after the toggle (K2 is rewritten in row 4),
  // far longer than the synchroniser delay, so they are sampled safely.
  logic [2:0] evt_sync_reg;
  logic [1:0] ais_sync_reg;
  logic [1:0] tick_sync_reg;
  logic       tick_prev_reg;
  wire        frame_evt  = evt_sync_reg[2] ^ evt_sync_reg[1];
  wire        tick_evt   = tick_sync_reg[1] & ~tick_prev_reg;
  wire        ais_m      = ais_sync_reg[1];

  always_ff @(posedge mclk_in or negedge mrst_n) begin
    if (!mrst_n) begin
      evt_sync_reg  <= 3'h0;
      ais_sync_reg  <= 2'h0;
      tick_sync_reg <= 2'h0;
      tick_prev_reg <= 1'b0;
    end else begin
      evt_sync_reg  <= {evt_sync_reg[1:0], frame_evt_tgl_reg};
      ais_sync_reg  <= {ais_sync_reg[0], ais_defect_reg};
      tick_sync_reg <= {tick_sync_reg[0], one_second_tick_in};
      tick_prev_reg <= tick_sync_reg[1];
    end
  end

  // ------------------------------------------------------------------
  // Remote defect and degrade detection, management domain
  // ------------------------------------------------------------------
  logic [2:0]       rdi_run_reg;
  logic             remote_defect_reg;
  logic [CNT_W-1:0] deg_errs_reg;
  logic [3:0]       deg_bad_reg;
  logic             degrade_defect_reg;
  wire              rdi_frame = (k2_code_reg == K2_RDI_CODE);
  wire              deg_bad_sec = (deg_errs_reg >= CNT_W'(degrade_threshold_in));
  // A frame result that lands on the tick opens the new second instead of being lost.
  wire  [CNT_W-1:0] near_add    = frame_evt ? CNT_W'(blk_err_reg) : '0;
  wire  [CNT_W-1:0] far_add     = frame_evt ? CNT_W'(far_err_reg) : '0;

  always_ff @(posedge mclk_in or negedge mrst_n) begin
    if (!mrst_n) begin
      rdi_run_reg       <= 3'h0;
      remote_defect_reg <= 1'b0;
    end else if (frame_evt) begin
      if (rdi_frame != remote_defect_reg) begin
        if (rdi_run_reg == 3'(RDI_PERSIST - 1)) begin
          remote_defect_reg <= rdi_frame; // R4 R7
          rdi_run_reg       <= 3'h0;
        end else begin
          rdi_run_reg <= rdi_run_reg + 3'h1;
        end
      end else begin
        rdi_run_reg <= 3'h0;
      end
    end
  end

  // Degrade: a second is bad when its block errors reach the threshold;
  // the defect sets after the configured run of bad seconds, clears after
  // the same run of good ones.
  always_ff @(posedge mclk_in or negedge mrst_n) begin
    if (!mrst_n) begin
      deg_errs_reg       <= '0;
      deg_bad_reg        <= 4'h0;
      degrade_defect_reg <= 1'b0;
    end else if (tick_evt) begin
      deg_errs_reg <= near_add;
      if (deg_bad_sec != degrade_defect_reg) begin
        deg_bad_reg <= deg_bad_reg + 4'h1;
        if (deg_bad_reg + 4'h1 >= degrade_period_count_in) begin
          degrade_defect_reg <= deg_bad_sec; // R7
          deg_bad_reg        <= 4'h0;
        end
      end else begin
        deg_bad_reg <= 4'h0;
      end
    end else begin
      deg_errs_reg <= deg_errs_reg + near_add;
    end
  end

  // ------------------------------------------------------------------
  // Consequent actions, reports and performance counts
  // ------------------------------------------------------------------
  wire monitor_enable = termination_point_mode_in; // R13
  wire ais_rep_next   = monitor_enable & ais_m & ~incoming_server_fail_in
                        & alarm_indication_report_enable_in; // R9
  wire rdi_rep_next   = monitor_enable & remote_defect_reg & remote_defect_report_enable_in; // R10
  wire deg_rep_next   = monitor_enable & degrade_defect_reg; // R10
  wire ssf_rep_next   = monitor_enable & ais_m & server_fail_report_enable_in; // R11

  logic [CNT_W-1:0] near_acc_reg;
  logic [CNT_W-1:0] far_acc_reg;
  logic             near_ds_reg;
  logic             far_ds_reg;

  always_ff @(posedge mclk_in or negedge mrst_n) begin
    if (!mrst_n) begin
      trail_signal_fail_out       <= 1'b0;
      backward_defect_request_out <= 1'b0;
      trail_signal_degrade_out    <= 1'b0;
      alarm_indication_report_out <= 1'b0;
      remote_defect_report_out    <= 1'b0;
      degrade_report_out          <= 1'b0;
      server_fail_report_out      <= 1'b0;
      backward_error_value_out    <= 9'h000;
    end else begin
      trail_signal_fail_out       <= ais_m; // R8
      backward_defect_request_out <= ais_m; // R8
      trail_signal_degrade_out    <= degrade_defect_reg; // R7
      alarm_indication_report_out <= ais_rep_next; // R9
      remote_defect_report_out    <= rdi_rep_next; // R10
      degrade_report_out          <= deg_rep_next; // R10
      server_fail_report_out      <= ssf_rep_next; // R11
      if (frame_evt) backward_error_value_out <= blk_err_reg; // R2
    end
  end

  always_ff @(posedge mclk_in or negedge mrst_n) begin
    if (!mrst_n) begin
      near_acc_reg               <= '0;
      far_acc_reg                <= '0;
      near_ds_reg                <= 1'b0;
      far_ds_reg                 <= 1'b0;
      near_error_block_count_out <= '0;
      far_error_block_count_out  <= '0;
      near_defect_second_out     <= 1'b0;
      far_defect_second_out      <= 1'b0;
    end else if (tick_evt) begin
      near_error_block_count_out <= near_acc_reg; // R14
      far_error_block_count_out  <= far_acc_reg;
      near_defect_second_out     <= near_ds_reg | ais_m | equipment_defect_in;
      far_defect_second_out      <= far_ds_reg | remote_defect_reg;
      near_acc_reg               <= near_add; // R12 R14
      far_acc_reg                <= far_add;
      near_ds_reg                <= 1'b0;
      far_ds_reg                 <= 1'b0;
    end else begin
      near_acc_reg <= near_acc_reg + near_add; // R12
      far_acc_reg  <= far_acc_reg + far_add; // R12 R3
      near_ds_reg <= near_ds_reg | ais_m | equipment_defect_in; // R12
      far_ds_reg  <= far_ds_reg | remote_defect_reg; // R12
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence ais_seen_s;
    $rose(ais_m);
  endsequence

  ais_fail_follow_a: assert property (@(posedge mclk_in) disable iff (!mrst_n) // R8
    ais_seen_s |=> trail_signal_fail_out && backward_defect_request_out)
    else $error("trail fail did not follow AIS defect");
  ais_report_gate_a: assert property (@(posedge mclk_in) disable iff (!mrst_n) // R9
    alarm_indication_report_out |-> $past(ais_m) && !$past(incoming_server_fail_in))
    else $error("AIS report raised without its conditions");
  ssf_report_gate_a: assert property (@(posedge mclk_in) disable iff (!mrst_n) // R11
    server_fail_report_out |-> $past(ais_m) && $past(server_fail_report_enable_in))
    else $error("server fail report raised without AIS defect");
  monitor_off_quiet_a: assert property (@(posedge mclk_in) disable iff (!mrst_n) // R13
    !termination_point_mode_in |=> !alarm_indication_report_out && !degrade_report_out
      && !remote_defect_report_out && !server_fail_report_out)
    else $error("report raised while not monitored");
  rdi_report_gate_a: assert property (@(posedge mclk_in) disable iff (!mrst_n) // R10
    remote_defect_report_out |-> $past(remote_defect_reg) && $past(remote_defect_report_enable_in))
    else $error("remote defect report without its conditions");
  tick_clear_acc_a: assert property (@(posedge mclk_in) disable iff (!mrst_n) // R14
    tick_evt |=> near_acc_reg == ($past(frame_evt) ? CNT_W'($past(blk_err_reg)) : '0)
      && far_acc_reg == ($past(frame_evt) ? CNT_W'($past(far_err_reg)) : '0))
    else $error("accumulators not restarted on tick");
  ones_on_ais_a: assert property (@(posedge link_clk_in) disable iff (!lrst_n) // R8
    ais_defect_reg |=> line_data_out == ALL_ONES_BYTE)
    else $error("data not all ones during AIS");
  ais_persist_a: assert property (@(posedge link_clk_in) disable iff (!lrst_n) // R5
    $rose(ais_defect_reg) |-> $past(ais_run_reg) == 3'(AIS_PERSIST - 1))
    else $error("AIS declared before persistence count");
  degrade_out_a: assert property (@(posedge mclk_in) disable iff (!mrst_n) // R7
    degrade_defect_reg |=> trail_signal_degrade_out)
    else $error("degrade output not following defect");
endmodule

// ---- inc/trail_sink_pkg.sv ----
package trail_sink_pkg;
  // ------------------------------------------------------------------
  // Frame geometry (byte-wide link, one byte per link clock)
  // ------------------------------------------------------------------
  localparam int unsigned ROW_BYTES        = 4320;
  localparam int unsigned ROWS             = 9;
  localparam int unsigned REGENERATOR_OVERHEAD_COLS        = 48;
  localparam int unsigned OH_COLS          = 144;
  localparam int unsigned BIP_LANES        = 48;
  localparam int unsigned B2_ROW           = 4;
  localparam int unsigned K2_ROW           = 4;
  localparam int unsigned K2_COL           = 96;
  localparam int unsigned M1_ROW           = 8;
  localparam int unsigned M1_COL           = 143;
  // ------------------------------------------------------------------
  // Overhead codes and persistence
  // ------------------------------------------------------------------
  localparam logic [2:0]  K2_RDI_CODE      = 3'h6;
  localparam logic [2:0]  K2_AIS_CODE      = 3'h7;
  localparam int unsigned AIS_PERSIST      = 3;
  localparam logic [7:0]  ALL_ONES_BYTE    = 8'hff;
  localparam int unsigned RDI_PERSIST      = 5;
  // ------------------------------------------------------------------
  // Timing and counter width
  // ------------------------------------------------------------------
  localparam int unsigned AIS_ACTION_US    = 250;
  localparam int unsigned LINK_MHZ         = 167;
  localparam int unsigned AIS_ACTION_CYC   = AIS_ACTION_US * LINK_MHZ;
  localparam int unsigned CNT_W            = 32;
endpackage

// ---- rtl/bip_lane_sum.sv ----
`timescale 1ns/1ps
// Counts lanes whose computed parity byte differs from the received one.
module bip_lane_sum
  import trail_sink_pkg::*;
#(
  parameter int unsigned LANES = BIP_LANES
) (
  input  wire logic [LANES*8-1:0] calc_in,
  input  wire logic [LANES*8-1:0] rcvd_in,
  output logic      [8:0]         errors_out
);
  always_comb begin
    errors_out = 9'h000;
    for (int i = 0; i < LANES; i++) begin
      errors_out = errors_out + {8'h00, |(calc_in[i*8 +: 8] ^ rcvd_in[i*8 +: 8])};
    end
  end
endmodule

// ---- tb/section_feed.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Upstream source: framed bytes with B2 parity, K2 code and M1 count
// ------------------------------------------------------------------
module section_feed
  import trail_sink_pkg::*;
#(
  parameter int unsigned ROW_LEN = ROW_BYTES
) (
  input  wire logic       link_clk_in,
  input  wire logic       run_in,
  input  wire logic [2:0] k2_code_in,
  input  wire logic [7:0] m1_value_in,
  input  wire logic [5:0] bad_lanes_in,
  output logic      [7:0] line_data_out,
  output logic            frame_start_out
);
  logic [7:0]  acc [BIP_LANES];
  logic [7:0]  prev [BIP_LANES];
  logic [7:0]  b, m1;
  logic [5:0]  bad;
  int unsigned pos, row, col, lane;
  int          seed;
  initial begin
    seed = 39444;
    pos = 0;
    line_data_out = 8'h00;
    frame_start_out = 1'b0;
    foreach (acc[i]) acc[i] = 8'h00;
  end
  // Outside a run the line toggles, so no stale byte can pass for data.
  // The K2 code shares its byte with parity lane 0, so a late lane-0 byte
  // steers that lane's parity to carry the code of the next frame.
  always @(posedge link_clk_in) begin
    if (!run_in) begin
      pos = 0;
      frame_start_out <= 1'b0;
      line_data_out <= ~line_data_out;
    end else begin
      row = pos / ROW_LEN;
      col = pos % ROW_LEN;
      lane = col % BIP_LANES;
      if (pos == 0) begin
        prev = acc;
        foreach (acc[i]) acc[i] = 8'h00;
        m1 = m1_value_in;
        bad = bad_lanes_in;
      end
      b = 8'($random(seed));
      if (row == B2_ROW && col >= OH_COLS - BIP_LANES) begin
        b = prev[lane] ^ ((lane >= BIP_LANES - bad) ? 8'h80 : 8'h00);
      end else if (row == M1_ROW && col == M1_COL) begin
        b = m1;
      end else if (row == M1_ROW && col == K2_COL) begin
        b = acc[lane] ^ {5'h00, k2_code_in};
      end
      if (row > 2 || col >= OH_COLS) begin
        acc[lane] = acc[lane] ^ b;
      end
      line_data_out <= b;
      frame_start_out <= (pos == 0);
      pos = (pos + 1) % (ROW_LEN * ROWS);
    end
  end
endmodule

// ---- tb/test_section_trail_sink.sv ----
`timescale 1ns/1ps
module test_section_trail_sink;
  import trail_sink_pkg::*;
  localparam int unsigned RL = 144;
  logic             mclk_in = 1'b0, rst_n_in = 1'b0, lclk = 1'b0, run = 1'b0;
  logic             ssf = 1'b0, eqd = 1'b0, tick = 1'b0, mon = 1'b1;
  logic             ssf_en = 1'b1, ais_en = 1'b1, rdi_en = 1'b1;
  logic [15:0]      thr = 16'h0001;
  logic [3:0]       per = 4'h2;
  logic [2:0]       k2 = 3'h0;
  logic [7:0]       m1 = 8'h00, din, dout, prev_in, m;
  logic [5:0]       bad = 6'h00, e;
  logic             fs, fs_out, prev_fs, tsf, tsd, ais_r, deg_r, rdi_r, ssf_r, nds, fds, bdr;
  logic [CNT_W-1:0] nebc, febc;
  logic [8:0]       bev;
  int               num_errors = 0, check_count = 0, seed = 39444, frames = 0;

  always #2 mclk_in = ~mclk_in;
  initial begin
    #1.3;
    forever #3 lclk = ~lclk;
  end
  always @(posedge lclk) begin
    prev_in <= din;
    prev_fs <= fs;
    if (fs) frames <= frames + 1;
  end

  section_feed #(.ROW_LEN(RL)) feed (.link_clk_in(lclk), .run_in(run), .k2_code_in(k2),
    .m1_value_in(m1), .bad_lanes_in(bad), .line_data_out(din), .frame_start_out(fs));

  section_trail_sink #(.ROW_LEN(RL)) dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .link_clk_in(lclk), .line_data_in(din), .frame_start_in(fs), .incoming_server_fail_in(ssf),
    .equipment_defect_in(eqd), .degrade_threshold_in(thr), .degrade_period_count_in(per),
    .one_second_tick_in(tick), .termination_point_mode_in(mon), .server_fail_report_enable_in(ssf_en),
    .alarm_indication_report_enable_in(ais_en), .remote_defect_report_enable_in(rdi_en),
    .line_data_out(dout), .frame_start_out(fs_out), .trail_signal_fail_out(tsf),
    .trail_signal_degrade_out(tsd), .alarm_indication_report_out(ais_r), .degrade_report_out(deg_r),
    .remote_defect_report_out(rdi_r), .server_fail_report_out(ssf_r),
    .near_error_block_count_out(nebc), .far_error_block_count_out(febc),
    .near_defect_second_out(nds), .far_defect_second_out(fds),
    .backward_error_value_out(bev), .backward_defect_request_out(bdr));

  // ------------------------------------------------------------------
  // Checking and pacing
  // ------------------------------------------------------------------
  task automatic end_sim;
    $display("Checks %0d, errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Two per-frame results fall inside every one-second window.
  function automatic logic [31:0] per_second(input logic [31:0] per_frame);
    return per_frame * 32'h2;
  endfunction

  function automatic logic report_gate(input logic mon_on, input logic defect_on, input logic enable_on);
    return mon_on & defect_on & enable_on;
  endfunction

  // Ends 20 cycles after a frame start, once per-frame results have crossed.
  task automatic wait_frames(input int k);
    int target, n;
    target = frames + k;
    n = 0;
    while (frames < target) begin
      @(posedge mclk_in);
      n++;
      if (n > 2500 * k) begin
        num_errors++;
        end_sim();
      end
    end
    repeat (20) @(posedge mclk_in);
  endtask

  task automatic pulse_tick;
    tick <= 1'b1;
    repeat (4) @(posedge mclk_in);
    tick <= 1'b0;
    repeat (8) @(posedge mclk_in);
  endtask

  task automatic check_data(input logic ones);
    repeat (50) begin
      @(negedge lclk);
      cmp({fs_out, dout}, {prev_fs, ones ? 8'hff : prev_in});
    end
    @(posedge mclk_in);
  endtask

  // Ticks fall just after a frame start, once its result has crossed, so each second holds exactly two frame results.
  task automatic window(input logic [5:0] ev, input logic [7:0] mv);
    bad <= ev;
    m1 <= mv;
    wait_frames(2);
    cmp(bev, ev);
    pulse_tick();
    wait_frames(2);
    cmp(bev, ev);
    pulse_tick();
    cmp(nebc, per_second(ev));
    cmp(febc, per_second(mv));
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    cmp({tsf, bdr, bev}, 0);
    repeat (10) @(posedge mclk_in);
    run <= 1'b1;
    wait_frames(3);
    pulse_tick();
    e = 6'(1 + ($unsigned($random(seed)) % 47));
    m = 8'($random(seed));
    window(e, m);
    window(6'd48, m ^ 8'h5a);
    cmp({tsd, deg_r}, 2'b11);
    window(6'd0, 8'hff);
    window(6'd0, 8'h00);
    cmp({tsd, deg_r}, 2'b00);
    check_data(1'b0);
    k2 <= K2_AIS_CODE;
    wait_frames(3);
    cmp(tsf, 0);
    wait_frames(1);
    cmp({tsf, bdr}, 2'b11);
    check_data(1'b1);
    for (int i = 0; i < 16; i++) begin
      {mon, ssf, ais_en, ssf_en} <= 4'(i);
      repeat (3) @(posedge mclk_in);
      cmp(ais_r, report_gate(mon, ~ssf, ais_en));
      cmp(ssf_r, report_gate(mon, 1'b1, ssf_en));
    end
    {mon, ssf, ais_en, ssf_en} <= 4'hb;
    pulse_tick();
    cmp(nds, 1);
    k2 <= K2_RDI_CODE;
    wait_frames(3);
    cmp(tsf, 1);
    wait_frames(1);
    cmp({tsf, bdr, rdi_r}, 3'b000);
    check_data(1'b0);
    pulse_tick();
    wait_frames(2);
    for (int i = 0; i < 4; i++) begin
      {mon, rdi_en} <= 2'(i);
      repeat (3) @(posedge mclk_in);
      cmp(rdi_r, report_gate(mon, 1'b1, rdi_en));
    end
    eqd <= 1'b1;
    k2 <= 3'h0;
    pulse_tick();
    cmp({nds, fds}, 2'b11);
    eqd <= 1'b0;
    wait_frames(6);
    pulse_tick();
    wait_frames(1);
    pulse_tick();
    cmp({nds, fds, rdi_r}, 3'b000);
    end_sim();
  end
endmodule
